// ### dv/tap_access_gate_regs_tb.sv
/*
 * self-checking bench for the scan access gate registers.
 * assumes the register port of the design and the router model beside it.
 */
`timescale 1ns/10ps
module tap_access_gate_regs_tb;
	import tap_gate_pkg::*;
	logic clk = 0, rst = 1, known = 0, secure = 0, wr_s = 0, rd_s = 0;
	logic [FUSE_W-1:0] fuse = '0, f;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, mask, exp0, val;
	logic [TEST_W-1:0] test_en;
	logic [DEBUG_W-1:0] dbg_en;
	int num_errors = 0, compares = 0;
	tap_access_gate_regs tap_access_gate_regs_inst (.CLK(clk), .SYS_RST(rst), .TYPE_KNOWN(known),
		.TYPE_SECURE(secure), .RESERVED_FUSE_BITS(fuse), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .TEST_PORT_ENABLE_OUT(test_en), .DEBUG_PORT_ENABLE_OUT(dbg_en));
	tap_router_model tap_router_model_inst (.test_en(test_en), .debug_en(dbg_en), .sel_mask(mask));
	initial begin
		forever #5 clk = ~clk;
	end
	// ***************
	// access tasks
	// ***************
	task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 check(rdata, exp);
	endtask : rd
	task settle(input logic [DATA_W-1:0] exp);
		repeat (2) @(posedge clk);
		#1 check(mask, exp);
	endtask : settle
	task close_out;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// ***************
	// sequence
	// ***************
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		$display("unexpected at %0t: run did not finish", $time);
		close_out;
	end
	initial begin
		// pass 0 secure part, pass 1 non-secure part after a second power-on reset
		for (int s = 0; s < 2; s++) begin
			repeat (3) @(posedge clk);
			rst <= 1'b0;
			exp0 = s ? RESET_NONSECURE : RESET_SECURE;
			val = s ? 32'h5a3c_0ff1 : 32'ha5c3_0f96;
			f = s ? 24'h3c_e1a5 : 24'h5a_c3e1;
			wr(SCAN_ACCESS_ENABLE_OFS, 32'h1234_5678);
			rd(SCAN_ACCESS_ENABLE_OFS, 32'h0000_0000);
			settle(32'h0000_0000);
			@(posedge clk);
			known <= 1'b1;
			secure <= (s == 0);
			@(posedge clk);
			known <= 1'b0;
			settle(exp0);
			rd(SCAN_ACCESS_ENABLE_OFS, exp0);
			rd(TYPE_STATUS_OFS, {30'h0, (s == 0), 1'b1});
			wr(SCAN_ACCESS_ENABLE_OFS, val);
			settle(val);
			wr(SCAN_ACCESS_ENABLE_OFS, ~val);
			settle(val);
			rd(SCAN_ACCESS_ENABLE_OFS, val);
			@(posedge clk);
			fuse <= f;
			rd(RESERVED_FUSE_STATUS_OFS, {8'h00, f});
			wr(RESERVED_FUSE_STATUS_OFS, 32'hffff_ffff);
			rd(RESERVED_FUSE_STATUS_OFS, {8'h00, f});
			rd(8'h0c, UNMAPPED_READ);
			settle(val);
			@(posedge clk);
			rst <= 1'b1;
		end
		close_out;
	end
endmodule : tap_access_gate_regs_tb

// ### dv/tap_router_model.sv
/*
 * behavioural model of the scan router that sits behind the enable outputs.
 * assumes enables are level signals, active high, one per selectable port.
 */
`timescale 1ns/10ps
module tap_router_model
	import tap_gate_pkg::*;
(
	input wire logic [tap_gate_pkg::TEST_W-1:0] test_en,
	input wire logic [tap_gate_pkg::DEBUG_W-1:0] debug_en,
	output logic [tap_gate_pkg::DATA_W-1:0] sel_mask
);
	assign sel_mask = {test_en, debug_en};
endmodule : tap_router_model

// ### logic/tap_access_gate_regs.sv
/*
 * scan access gate registers: the tap enable register with its per-bit
 * enable outputs to the tap router, and the reserved fuse status word.
 * assumes SYS_RST is the power-on reset and TYPE_KNOWN pulses or rises
 * once the device type is settled, with TYPE_SECURE valid beside it.
 */
// Local design decisions: the register addresses and the strobed register port.
// Contract
// RL1: every tap enable bit drives its own enable output to the router
// RL2: reset value of tap enable loads only once device type is known
// RL3: non-secure resets to all ones, secure to upper ones lower zeros
// RL4: each tap enable bit accepts one write, later writes ignored
// RL5: written value persists until the next power-on reset
// RL6: bits 31-16 drive the test port enable bus
// RL7: bits 15-0 drive the debug port enable bus
// RL8: fuse status shows reserved fuse bits read-only in bits 23-0
// RL9: fuse status bits 31-24 read zero, writes ignored
// RL10: per-bit written flag set by first write, cleared by power-on reset
`timescale 1ns/10ps
module tap_access_gate_regs
	import tap_gate_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic TYPE_KNOWN,
	input wire logic TYPE_SECURE,
	input wire logic [tap_gate_pkg::FUSE_W-1:0] RESERVED_FUSE_BITS,
	input wire logic [tap_gate_pkg::ADDR_W-1:0] ADDR,
	input wire logic [tap_gate_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [tap_gate_pkg::DATA_W-1:0] RDATA,
	output logic [tap_gate_pkg::TEST_W-1:0] TEST_PORT_ENABLE_OUT,
	output logic [tap_gate_pkg::DEBUG_W-1:0] DEBUG_PORT_ENABLE_OUT
);
	import tap_gate_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		type_state_t type_st_r;
		logic secure_r;
		logic [DATA_W-1:0] rdata_r;
		logic [TEST_W-1:0] test_en_r;
		logic [DEBUG_W-1:0] debug_en_r;
	} top_state_t;
	top_state_t s_r;
	top_state_t s_nxt;

	logic load;
	logic wr_enable;
	logic [DATA_W-1:0] tap_value;
	logic [DATA_W-1:0] tap_written;
	logic [DATA_W-1:0] load_value;
	logic type_latched;

	// ****************************************
	// helpers
	// ****************************************
	// reset value that belongs to the device type
	function automatic logic [DATA_W-1:0] reset_for(input logic secure);
		reset_for = secure ? RESET_SECURE : RESET_NONSECURE;
	endfunction : reset_for

	// one decode per address for the checks; the port logic uses only is_tap_addr, for write gating
	function automatic logic is_tap_addr(input logic [ADDR_W-1:0] a);
		is_tap_addr = (a == SCAN_ACCESS_ENABLE_OFS);
	endfunction : is_tap_addr

	function automatic logic is_fuse_addr(input logic [ADDR_W-1:0] a);
		is_fuse_addr = (a == RESERVED_FUSE_STATUS_OFS);
	endfunction : is_fuse_addr

	function automatic logic is_status_addr(input logic [ADDR_W-1:0] a);
		is_status_addr = (a == TYPE_STATUS_OFS);
	endfunction : is_status_addr

	// the upper byte has no storage behind it, so it is padded with zeros
	function automatic logic [DATA_W-1:0] fuse_word(input logic [FUSE_W-1:0] bits);
		fuse_word = {{(DATA_W-FUSE_W){1'b0}}, bits};
	endfunction : fuse_word

	// bit 0 says the type is latched, bit 1 that the part is secure
	function automatic logic [DATA_W-1:0] status_word(input logic secure, input logic latched);
		status_word = {{(DATA_W-2){1'b0}}, secure, latched};
	endfunction : status_word

	// ****************************************
	// type latch and write gating
	// ****************************************
	assign type_latched = (s_r.type_st_r == TYPE_LATCHED);
	// RL2 load once type known
	assign load = !type_latched && TYPE_KNOWN;
	// RL3 type dependent reset value
	assign load_value = reset_for(TYPE_SECURE);
	// writes before the type is known would be overwritten by the load, so hold them off
	assign wr_enable = WR && is_tap_addr(ADDR) && type_latched;

	write_once_bits #(
		.WIDTH(DATA_W)
	) u_bits (
		.clk(CLK),
		.rst(SYS_RST),
		.load(load),
		.load_value(load_value),
		.wr(wr_enable),
		.wr_data(WDATA),
		.value(tap_value),
		.written(tap_written)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.type_st_r)
			TYPE_WAIT: begin
				if (TYPE_KNOWN) begin
					s_nxt.type_st_r = TYPE_LATCHED;
					s_nxt.secure_r = TYPE_SECURE;
				end
			end
			TYPE_LATCHED: begin
			end
		endcase
		// RL1 per bit enable outputs
		// RL6 upper half to test port
		s_nxt.test_en_r = tap_value[TEST_LSB +: TEST_W];
		// RL7 lower half to debug port
		s_nxt.debug_en_r = tap_value[DEBUG_LSB +: DEBUG_W];
		s_nxt.rdata_r = UNMAPPED_READ;
		if (RD) begin
			unique case (ADDR)
				SCAN_ACCESS_ENABLE_OFS: s_nxt.rdata_r = tap_value;
				// RL8 fuse bits read-only
				// RL9 upper byte reads zero
				RESERVED_FUSE_STATUS_OFS: s_nxt.rdata_r = fuse_word(RESERVED_FUSE_BITS);
				TYPE_STATUS_OFS: s_nxt.rdata_r = status_word(s_r.secure_r, type_latched);
				default: s_nxt.rdata_r = UNMAPPED_READ;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// outputs stay closed (zero) until the type is known, the safe default
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.rdata_r;
	assign TEST_PORT_ENABLE_OUT = s_r.test_en_r;
	assign DEBUG_PORT_ENABLE_OUT = s_r.debug_en_r;

	// ****************************************
	// checks: type latch
	// ****************************************
	// RL2 type latched once
	a_load_only_once: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		type_latched |=> (type_latched && $stable(s_r.secure_r)))
		else $error("device type latched twice");

	// RL2 wait without type
	a_type_waits: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		(!type_latched && !TYPE_KNOWN) |=> !type_latched)
		else $error("type latched without strobe");

	// RL2 latch on strobe
	a_type_latches: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		(!type_latched && TYPE_KNOWN) |=> (type_latched && (s_r.secure_r == $past(TYPE_SECURE))))
		else $error("device type not latched");

	// RL2 single load pulse
	a_load_single: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		load |=> !load)
		else $error("reset value loaded twice");

	// RL2 closed before type
	a_closed_before_type: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		!type_latched |-> ((tap_value == '0) && (tap_written == '0)))
		else $error("tap enable set before type known");

	// RL2 outputs closed early
	a_outputs_closed: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		!type_latched |=> ((TEST_PORT_ENABLE_OUT == '0) && (DEBUG_PORT_ENABLE_OUT == '0)))
		else $error("enable outputs open before type known");

	// RL2 early write dropped
	a_early_write_dropped: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		(WR && is_tap_addr(ADDR) && !type_latched) |=> (tap_written == '0))
		else $error("tap write taken before type known");

	// RL2 early read zero
	a_early_read_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		(RD && is_tap_addr(ADDR) && !type_latched) |=> (RDATA == '0))
		else $error("tap read not zero before type known");

	// ****************************************
	// checks: reset values
	// ****************************************
	// RL3 reset value by type
	a_load_value_type: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
		load |=> (tap_value == ($past(TYPE_SECURE) ? RESET_SECURE : RESET_NONSECURE)))
		else $error("wrong reset value for device type");

	// RL3 value until written
	a_reset_until_write: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
		(type_latched && tap_written == '0) |->
		(tap_value == (s_r.secure_r ? RESET_SECURE : RESET_NONSECURE)))
		else $error("reset value lost before write");

	// RL3 secure part halves
	a_secure_halves: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
		(type_latched && s_r.secure_r && tap_written == '0) |=>
		((TEST_PORT_ENABLE_OUT == '1) && (DEBUG_PORT_ENABLE_OUT == '0)))
		else $error("secure part enables wrong");

	// RL3 non-secure all open
	a_nonsecure_open: assert property (@(posedge CLK) disable iff (SYS_RST) // RL3
		(type_latched && !s_r.secure_r && tap_written == '0) |=>
		({TEST_PORT_ENABLE_OUT, DEBUG_PORT_ENABLE_OUT} == '1))
		else $error("non-secure part enables wrong");

	// RL1 outputs after load
	a_outputs_after_load: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
		load |=> ##1 ({TEST_PORT_ENABLE_OUT, DEBUG_PORT_ENABLE_OUT} ==
		($past(TYPE_SECURE, 2) ? RESET_SECURE : RESET_NONSECURE)))
		else $error("enable outputs wrong after load");

	// ****************************************
	// checks: write-once
	// ****************************************
	// RL4 first write lands
	a_first_write_lands: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
		(wr_enable && tap_written == '0) |=> (tap_value == $past(WDATA)))
		else $error("first write not taken");

	// RL4 second write ignored
	a_second_write: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
		(wr_enable && tap_written == '1) |=> $stable(tap_value))
		else $error("second write changed value");

	// RL9 other writes ignored
	a_other_write_ignored: assert property (@(posedge CLK) disable iff (SYS_RST) // RL9
		(WR && !is_tap_addr(ADDR) && !load) |=> ($stable(tap_value) && $stable(tap_written)))
		else $error("write elsewhere touched tap enable");

	// RL5 value persists
	a_persist_value: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
		(tap_written == '1 && type_latched) |=> $stable(tap_value))
		else $error("written value lost");

	// RL5 value needs event
	a_value_needs_event: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
		(!wr_enable && !load) |=> $stable(tap_value))
		else $error("tap value changed on its own");

	// RL5 flags never clear
	a_flags_never_clear: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
		1'b1 |=> ((tap_written & $past(tap_written)) == $past(tap_written)))
		else $error("written flag cleared without reset");

	// RL10 write sets flags
	a_written_flag: assert property (@(posedge CLK) disable iff (SYS_RST) // RL10
		wr_enable |=> (tap_written == '1))
		else $error("written flags not set");

	// RL10 flags need write
	a_flags_need_write: assert property (@(posedge CLK) disable iff (SYS_RST) // RL10
		!wr_enable |=> $stable(tap_written))
		else $error("written flags changed without write");

	// ****************************************
	// checks: enable outputs
	// ****************************************
	// RL6 test half map
	a_test_out_map: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
		1'b1 |=> (TEST_PORT_ENABLE_OUT == $past(tap_value[TEST_LSB +: TEST_W])))
		else $error("test enable mismatch");

	// RL7 debug half map
	a_debug_out_map: assert property (@(posedge CLK) disable iff (SYS_RST) // RL7
		1'b1 |=> (DEBUG_PORT_ENABLE_OUT == $past(tap_value[DEBUG_LSB +: DEBUG_W])))
		else $error("debug enable mismatch");

	// RL1 every bit routed
	a_outputs_all_bits: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
		##1 ({TEST_PORT_ENABLE_OUT, DEBUG_PORT_ENABLE_OUT} == $past(tap_value)))
		else $error("enable outputs not per bit");

	// RL1 write reaches outputs
	a_outputs_follow_write: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
		(wr_enable && tap_written == '0) |=> ##1 ({TEST_PORT_ENABLE_OUT, DEBUG_PORT_ENABLE_OUT} == $past(WDATA, 2)))
		else $error("write did not reach enable outputs");

	// RL6 test half written
	a_write_sets_test: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
		(wr_enable && tap_written == '0) |=> ##1 (TEST_PORT_ENABLE_OUT == $past(WDATA[TEST_LSB +: TEST_W], 2)))
		else $error("test enables not from upper half");

	// RL7 debug half written
	a_write_sets_debug: assert property (@(posedge CLK) disable iff (SYS_RST) // RL7
		(wr_enable && tap_written == '0) |=> ##1 (DEBUG_PORT_ENABLE_OUT == $past(WDATA[DEBUG_LSB +: DEBUG_W], 2)))
		else $error("debug enables not from lower half");

	// RL6 test half holds
	a_test_bits_hold: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
		(type_latched && tap_written == '1) |=> ##1 $stable(TEST_PORT_ENABLE_OUT))
		else $error("test enables moved after write");

	// RL7 debug half holds
	a_debug_bits_hold: assert property (@(posedge CLK) disable iff (SYS_RST) // RL7
		(type_latched && tap_written == '1) |=> ##1 $stable(DEBUG_PORT_ENABLE_OUT))
		else $error("debug enables moved after write");

	// ****************************************
	// checks: register reads
	// ****************************************
	// RL1 tap enable readback
	a_tap_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
		(RD && is_tap_addr(ADDR)) |=> (RDATA == $past(tap_value)))
		else $error("tap enable misread");

	// RL8 fuse bits read
	a_fuse_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL8
		(RD && is_fuse_addr(ADDR)) |=>
		(RDATA[FUSE_W-1:0] == $past(RESERVED_FUSE_BITS)))
		else $error("fuse bits misread");

	// RL9 upper byte zero
	a_fuse_top_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // RL9
		(RD && is_fuse_addr(ADDR)) |=> (RDATA[DATA_W-1:FUSE_W] == '0))
		else $error("fuse upper byte not zero");

	// RL2 type status read
	a_status_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
		(RD && is_status_addr(ADDR)) |=>
		(RDATA == {{(DATA_W-2){1'b0}}, $past(s_r.secure_r), $past(type_latched)}))
		else $error("type status misread");

	// RL8 data one cycle
	a_read_one_cycle: assert property (@(posedge CLK) disable iff (SYS_RST) // RL8
		!RD |=> (RDATA == UNMAPPED_READ))
		else $error("read data stands without read");

	// RL9 unmapped reads zero
	a_unmapped_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL9
		(RD && !is_tap_addr(ADDR) && !is_fuse_addr(ADDR) && !is_status_addr(ADDR)) |=>
		(RDATA == UNMAPPED_READ))
		else $error("unmapped read not zero");
endmodule : tap_access_gate_regs

// ### logic/tap_gate_pkg.sv
/*
 * constants for the scan access gate register slice: register offsets,
 * field positions and per-device-type reset values.
 * assumes a 32-bit plain register port with byte addresses.
 */
package tap_gate_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int TEST_W = 16;
	localparam int DEBUG_W = 16;
	localparam int FUSE_W = 24;
	localparam logic [ADDR_W-1:0] SCAN_ACCESS_ENABLE_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] RESERVED_FUSE_STATUS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] TYPE_STATUS_OFS = 8'h08;
	localparam int TEST_LSB = 16;
	localparam int DEBUG_LSB = 0;
	localparam logic [DATA_W-1:0] RESET_NONSECURE = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] RESET_SECURE = 32'hffff_0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic {TYPE_WAIT, TYPE_LATCHED} type_state_t;
endpackage : tap_gate_pkg

// ### logic/write_once_bits.sv
/*
 * write-once register bits: each bit takes its load value on the load
 * strobe, then accepts exactly one software write until power-on reset.
 * assumes load arrives once and before any write is meaningful.
 */
`timescale 1ns/10ps
module write_once_bits #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic wr,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] value,
	output logic [WIDTH-1:0] written
);
	typedef struct packed {
		logic [WIDTH-1:0] value_r;
		logic [WIDTH-1:0] written_r;
	} wo_state_t;
	wo_state_t s_r;
	wo_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.value_r = load_value;
		end
		// RL4 single write accepted
		if (wr) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (!s_r.written_r[i]) begin
					s_nxt.value_r[i] = wr_data[i];
					// RL10 written flag set
					s_nxt.written_r[i] = 1'b1;
				end
			end
		end
	end

	// RL5 cleared only by power-on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign value = s_r.value_r;
	assign written = s_r.written_r;

	// a bit once written is not changed again by a write in a cycle without load
	a_written_stays: assert property (@(posedge clk) disable iff (rst) // RL4
		(wr && !load) |=> ((s_r.value_r & $past(s_r.written_r)) == ($past(s_r.value_r) & $past(s_r.written_r))))
		else $error("written bit changed");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // RL10
		wr |=> (s_r.written_r == '1))
		else $error("written flag not set by write");
endmodule : write_once_bits
